// [swl_loader.sv]
// Serial word loader of a current-output multiplying DAC.
// Assumes the link pins are asynchronous and are far slower than
// core_clk_i; the link clock is sampled, not used as a clock.
`timescale 1ns/1ps
`default_nettype none

`include "swl_regs.svh"

module swl_loader
  import swl_pkg::*;
#(
  parameter int DAC_BITS = 14
) (
  // Clock and reset
  input  wire logic                core_clk_i,
  input  wire logic                reset_i,
  input  wire logic                clk_en_i,
  // Serial link pins
  input  wire logic                frame_sync_n_i,
  input  wire logic                serial_clk_i,
  input  wire logic                serial_data_in_i,
  // Converter core side
  input  wire logic                dac_ready_i,
  output logic [DAC_BITS-1:0]      current_output_o,
  output logic                     dac_update_o,
  // Status
  output logic                     rising_mode_o,
  output logic                     word_ready_o,
  output logic                     overrun_o,
  output logic                     short_frame_o
);
  localparam logic [4:0] WORD_CNT = 5'(`SWL_WORD_BITS);
  localparam logic [2:0] PIN_IDLE = `SWL_PIN_IDLE;

  swl_pins_s               pins_raw;
  swl_pins_s               filt_s;
  swl_pins_s               prev_s;
  logic [2:0]              filt_v;
  logic [2:0]              prev_v;
  swl_state_e              state_ff;
  swl_state_e              nxt_state;
  logic [`SWL_WORD_BITS-1:0] shreg_ff;
  logic [`SWL_WORD_BITS-1:0] nxt_shreg;
  logic                    edge_mode_ff;
  logic [4:0]              bits_ff;
  logic [DAC_BITS-1:0]     code_ff;
  logic                    update_ff;
  logic                    overrun_ff;
  logic                    short_ff;
  logic                    frame_active;
  logic                    frame_fall;
  logic                    frame_rise;
  logic                    sclk_rise;
  logic                    sclk_fall;
  logic                    sample_evt;
  logic                    shift_evt;
  logic                    latch_now;
  logic                    latch_load;
  swl_ctrl_e               latch_ctrl;
  swl_word_s               push_word;
  swl_word_s               pop_word;
  logic                    pop_valid;
  logic                    pop_take;
  logic [DAC_BITS-1:0]     trimmed_code;

  // Edge detection on filtered pin levels
  function automatic logic fn_rise(input logic cur, input logic prv);
    return cur & ~prv;
  endfunction

  function automatic logic fn_fall(input logic cur, input logic prv);
    return ~cur & prv;
  endfunction

  // Control field decode
  function automatic swl_ctrl_e fn_ctrl(input logic [15:0] w);
    swl_word_s ws;
    ws = w;
    return swl_ctrl_e'({ws.control_bit_high, ws.control_bit_low});
  endfunction

  assign pins_raw = '{frame_n: frame_sync_n_i,
                      sclk:    serial_clk_i,
                      sdata:   serial_data_in_i};

  // Three-stage pin synchronisers with agreement filter
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      logic s1_ff;
      logic s2_ff;
      logic s3_ff;
      logic f_ff;
      logic p_ff;
      always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
          s1_ff <= PIN_IDLE[gi];
          s2_ff <= PIN_IDLE[gi];
          s3_ff <= PIN_IDLE[gi];
          f_ff  <= PIN_IDLE[gi];
          p_ff  <= PIN_IDLE[gi];
        end else if (clk_en_i) begin
          s1_ff <= pins_raw[gi];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
          if (s2_ff == s3_ff) begin
            f_ff <= s3_ff;
          end
          p_ff <= f_ff;
        end
      end
      assign filt_v[gi] = f_ff;
      assign prev_v[gi] = p_ff;
    end
  endgenerate

  assign filt_s = filt_v;
  assign prev_s = prev_v;

  assign frame_active = !filt_s.frame_n;
  assign frame_fall   = fn_fall(filt_s.frame_n, prev_s.frame_n);
  assign frame_rise   = fn_rise(filt_s.frame_n, prev_s.frame_n);
  assign sclk_rise    = fn_rise(filt_s.sclk, prev_s.sclk);
  assign sclk_fall    = fn_fall(filt_s.sclk, prev_s.sclk);
  assign sample_evt   = edge_mode_ff ? sclk_rise : sclk_fall;
  assign shift_evt    = clk_en_i && frame_active && sample_evt;
  assign nxt_shreg    = {shreg_ff[`SWL_WORD_BITS-2:0], filt_s.sdata};

  // Frame sequencing
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SWL_ST_IDLE: begin
        if (frame_fall) begin
          nxt_state = SWL_ST_SHIFT;
        end
      end
      SWL_ST_SHIFT: begin
        if (frame_rise) begin
          nxt_state = SWL_ST_LATCH;
        end
      end
      SWL_ST_LATCH: begin
        nxt_state = frame_fall ? SWL_ST_SHIFT : SWL_ST_IDLE;
      end
      default: begin
        nxt_state = SWL_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state_ff <= SWL_ST_IDLE;
    end else if (clk_en_i) begin
      state_ff <= nxt_state;
    end
  end

  // Shift register, sixteen bits, MSB first
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      shreg_ff <= `SWL_RST_SHIFT;
    end else if (shift_evt) begin
      shreg_ff <= nxt_shreg;
    end
  end

  // Bits seen in the current frame, saturating at a word
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      bits_ff <= `SWL_RST_BITS;
    end else if (clk_en_i) begin
      if (frame_fall) begin
        bits_ff <= `SWL_RST_BITS;
      end else if (shift_evt && bits_ff != WORD_CNT) begin
        bits_ff <= bits_ff + 5'h01;
      end
    end
  end

  // Latch decode at frame end
  assign latch_now  = (state_ff == SWL_ST_LATCH);
  assign latch_ctrl = fn_ctrl(shreg_ff);
  assign latch_load = latch_now && (latch_ctrl == SWL_CTL_LOAD);
  assign push_word  = shreg_ff;

  // Sampling edge, sticky until reset
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      edge_mode_ff <= `SWL_RST_EDGE;
    end else if (clk_en_i && latch_now && latch_ctrl == SWL_CTL_RISE) begin
      edge_mode_ff <= 1'b1;
    end
  end

  // Frame status pulses
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      overrun_ff <= 1'b0;
      short_ff   <= 1'b0;
    end else if (clk_en_i) begin
      overrun_ff <= latch_load && !word_ready_o;
      short_ff   <= latch_now && (bits_ff < WORD_CNT);
    end
  end

  // Words waiting for the converter core
  swl_fifo #(
    .WIDTH (`SWL_WORD_BITS),
    .DEPTH (`SWL_FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .reset_i     (reset_i),
    .clk_en_i    (clk_en_i),
    .in_valid_i  (latch_load),
    .in_ready_o  (word_ready_o),
    .in_data_i   (push_word),
    .out_valid_o (pop_valid),
    .out_ready_i (dac_ready_i),
    .out_data_o  (pop_word)
  );

  assign pop_take     = clk_en_i && pop_valid && dac_ready_i;
  assign trimmed_code = pop_word.data[`SWL_DATA_MSB -: DAC_BITS];

  // DAC register and output update
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      code_ff   <= `SWL_RST_CODE;
      update_ff <= 1'b0;
    end else if (clk_en_i) begin
      update_ff <= pop_take;
      if (pop_take) begin
        code_ff <= trimmed_code;
      end
    end
  end

  assign current_output_o = code_ff;
  assign dac_update_o     = update_ff;
  assign rising_mode_o    = edge_mode_ff;
  assign overrun_o        = overrun_ff;
  assign short_frame_o    = short_ff;

  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_frame_end;
    clk_en_i && frame_rise && state_ff == SWL_ST_SHIFT;
  endsequence

  sequence s_load_latch;
    clk_en_i && latch_now && latch_ctrl == SWL_CTL_LOAD && word_ready_o;
  endsequence

  property p_short_flag;
    clk_en_i && latch_now && bits_ff < WORD_CNT |=> short_frame_o;
  endproperty
  a_short_flag: assert property (p_short_flag)
    else $error("short frame not flagged");

  property p_trim;
    pop_take |=> current_output_o == $past(trimmed_code) && dac_update_o;
  endproperty
  a_trim: assert property (p_trim)
    else $error("output code not taken from top data bits");

  property p_fall_default;
    shift_evt && !edge_mode_ff |-> sclk_fall && !sclk_rise;
  endproperty
  a_fall_default: assert property (p_fall_default)
    else $error("shift on wrong clock edge");

  property p_rise_select;
    clk_en_i && latch_now && latch_ctrl == SWL_CTL_RISE
      |=> rising_mode_o ##1 rising_mode_o;
  endproperty
  a_rise_select: assert property (p_rise_select)
    else $error("rising edge not selected");

  property p_no_update_ctl;
    clk_en_i && latch_now && latch_ctrl != SWL_CTL_LOAD && !pop_valid
      |=> !pop_valid;
  endproperty
  a_no_update_ctl: assert property (p_no_update_ctl)
    else $error("non-load word queued for update");

  property p_sticky;
    rising_mode_o |=> rising_mode_o;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("rising edge mode lost");

  property p_reset_zero;
    $fell(reset_i) |-> shreg_ff == '0 && current_output_o == '0
      && !rising_mode_o && !dac_update_o;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("state not zero after reset");

  property p_frame_gate;
    $changed(shreg_ff) |-> $past(frame_active);
  endproperty
  a_frame_gate: assert property (p_frame_gate)
    else $error("bit shifted outside frame");

  property p_latch_step;
    s_frame_end |=> latch_now;
  endproperty
  a_latch_step: assert property (p_latch_step)
    else $error("frame end did not latch");

  property p_load_queue;
    s_load_latch |=> pop_valid;
  endproperty
  a_load_queue: assert property (p_load_queue)
    else $error("loaded word not queued");

  property p_long_frame;
    shift_evt && !frame_fall && bits_ff == WORD_CNT
      |=> bits_ff == WORD_CNT && shreg_ff == $past(nxt_shreg);
  endproperty
  a_long_frame: assert property (p_long_frame)
    else $error("bit past the sixteenth not kept");

  property p_msb_first;
    shift_evt |=> shreg_ff[0] == $past(filt_v[0])
      && shreg_ff == $past(nxt_shreg);
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("shift order wrong");
endmodule

`default_nettype wire

// [swl_regs.svh]
// Constants of the serial DAC word loader: field positions,
// reset values and sizes. Included by the package and the loader.
`ifndef SWL_REGS_SVH
`define SWL_REGS_SVH

// Word layout
`define SWL_WORD_BITS    16
`define SWL_CTRL_HI_POS  15
`define SWL_CTRL_LO_POS  14
`define SWL_DATA_MSB     13
`define SWL_DATA_BITS    14

// Reset values
`define SWL_RST_SHIFT    16'h0000
`define SWL_RST_CODE     '0
`define SWL_RST_EDGE     1'b0
`define SWL_RST_BITS     5'h00
// Idle pin levels: frame sync high, clock and data low
`define SWL_PIN_IDLE     3'h4

// Buffering
`define SWL_FIFO_DEPTH   32

`endif

// [swl_pkg.sv]
// Types shared by the serial DAC word loader files.
// Assumes swl_regs.svh is on the include path.
`default_nettype none

package swl_pkg;
  `include "swl_regs.svh"

  typedef enum logic [1:0] {
    SWL_CTL_LOAD = 2'h0,
    SWL_CTL_RSV1 = 2'h1,
    SWL_CTL_RSV2 = 2'h2,
    SWL_CTL_RISE = 2'h3
  } swl_ctrl_e;

  typedef struct packed {
    logic                     control_bit_high;
    logic                     control_bit_low;
    logic [`SWL_DATA_MSB:0]   data;
  } swl_word_s;

  typedef struct packed {
    logic frame_n;
    logic sclk;
    logic sdata;
  } swl_pins_s;

  typedef enum logic [2:0] {
    SWL_ST_IDLE  = 3'h1,
    SWL_ST_SHIFT = 3'h2,
    SWL_ST_LATCH = 3'h4
  } swl_state_e;
endpackage

`default_nettype wire

// [swl_fifo.sv]
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock; clock enable low freezes all state.
`timescale 1ns/1ps
`default_nettype none

module swl_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             reset_i,
  input  wire logic             clk_en_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_idx_ff;
  logic [AW-1:0]    rd_idx_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_ff != FULL);
  assign out_valid_o = (count_ff != '0);
  assign out_data_o  = mem_ff[rd_idx_ff];
  assign push        = clk_en_i && in_valid_i && in_ready_o;
  assign pop         = clk_en_i && out_valid_o && out_ready_i;

  // Storage
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_ff[wr_idx_ff] <= in_data_i;
    end
  end

  // Pointers and fill level
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wr_idx_ff <= '0;
      rd_idx_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_idx_ff <= wr_idx_ff + AW'(1);
      end
      if (pop) begin
        rd_idx_ff <= rd_idx_ff + AW'(1);
      end
      if (push && !pop) begin
        count_ff <= count_ff + (AW+1)'(1);
      end else if (pop && !push) begin
        count_ff <= count_ff - (AW+1)'(1);
      end
    end
  end
endmodule

`default_nettype wire

// [swl_host_model.sv]
// Host side of the three-wire link: frame sync, link clock, data.
// Assumes one task runs at a time; link clock period is 200 ns.
`timescale 1ns/1ps
`default_nettype none

module swl_host_model (
  // Link pins
  output var logic frame_sync_n_o,
  output var logic serial_clk_o,
  output var logic serial_data_o
);
  initial begin
    frame_sync_n_o = 1'b1;
    serial_clk_o   = 1'b0;
    serial_data_o  = 1'b0;
  end

  // One frame of nbits, highest index first
  task automatic send(input logic [31:0] bits, input int nbits);
    #7 frame_sync_n_o = 1'b0;
    #200;
    for (int i = nbits - 1; i >= 0; i--) begin
      #50 serial_data_o = bits[i];
      #50 serial_clk_o = 1'b1;
      #100 serial_clk_o = 1'b0;
    end
    #100 frame_sync_n_o = 1'b1;
    serial_data_o = ~serial_data_o;
    #200;
  endtask

  // Clock and data toggling with frame sync high
  task automatic idle_noise(input int edges);
    for (int i = 0; i < edges; i++) begin
      #100 serial_clk_o = ~serial_clk_o;
      serial_data_o = ~serial_data_o;
    end
    #100 serial_clk_o = 1'b0;
  endtask
endmodule

`default_nettype wire

// [tb.sv]
// Self-checking bench of the serial word loader, 12-bit variant.
// Assumes the host model drives the link; core clock 40 MHz.
`timescale 1ns/1ps
`default_nettype none

module tb;
  import swl_pkg::*;
  localparam int DB = 12;

  logic          core_clk;
  logic          reset;
  logic          dac_ready;
  logic          clk_en;
  wire logic     frame_sync_n;
  wire logic     serial_clk;
  wire logic     serial_data;
  logic [DB-1:0] current_output;
  logic          dac_update;
  logic          rising_mode;
  logic          word_ready;
  logic          overrun;
  logic          short_frame;
  logic [DB-1:0] exp_q[$];
  int            num_errors = 0;
  int            num_checks = 0;
  int            n_over = 0;
  int            n_short = 0;
  integer        seed = 59;
  logic [11:0]   s;

  swl_loader #(.DAC_BITS(DB)) dut (
    .core_clk_i       (core_clk),
    .reset_i          (reset),
    .clk_en_i         (clk_en),
    .frame_sync_n_i   (frame_sync_n),
    .serial_clk_i     (serial_clk),
    .serial_data_in_i (serial_data),
    .dac_ready_i      (dac_ready),
    .current_output_o (current_output),
    .dac_update_o     (dac_update),
    .rising_mode_o    (rising_mode),
    .word_ready_o     (word_ready),
    .overrun_o        (overrun),
    .short_frame_o    (short_frame)
  );

  swl_host_model host (
    .frame_sync_n_o (frame_sync_n),
    .serial_clk_o   (serial_clk),
    .serial_data_o  (serial_data)
  );

  always #12.5 core_clk = ~core_clk;

  task automatic check(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic print_verdict();
    if (num_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic expect_data(input logic [13:0] d);
    exp_q.push_back(d[13 -: DB]);
  endtask

  // Control field on top, data left-justified below
  task automatic send_word(input logic [1:0] ctl, input logic [13:0] d);
    if (ctl == SWL_CTL_LOAD) begin
      expect_data(d);
    end
    host.send({16'h0000, ctl, d}, 16);
  endtask

  task automatic wait_empty();
    for (int i = 0; i < 2000 && exp_q.size() != 0; i++) begin
      @(negedge core_clk);
    end
    check("pending updates", 16'h0, 16'(exp_q.size()));
  endtask

  // Result watcher
  always @(negedge core_clk) begin
    if (reset === 1'b0 && overrun === 1'b1) n_over++;
    if (reset === 1'b0 && short_frame === 1'b1) n_short++;
    if (reset === 1'b0 && dac_update === 1'b1) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("BAD update expected none seen %h", current_output);
      end else begin
        check("current_output", 16'(exp_q.pop_front()),
              16'(current_output));
      end
    end
  end

  initial begin
    #1ms;
    num_errors++;
    print_verdict();
  end

  initial begin
    core_clk  = 1'b0;
    reset     = 1'b1;
    dac_ready = 1'b1;
    clk_en    = 1'b1;
    repeat (10) @(negedge core_clk);
    reset = 1'b0;
    check("current_output", 16'h0, 16'(current_output));
    check("rising_mode", 16'h0, 16'(rising_mode));
    check("word_ready", 16'h1, 16'(word_ready));
    repeat (4) @(negedge core_clk);
    for (int i = 0; i < 9; i++) begin
      send_word(2'(i % 3), 14'($random(seed)));
    end
    wait_empty();
    // Short frame after noise outside a frame
    send_word(2'h0, 14'h1230);
    host.idle_noise(6);
    s = 12'($random(seed));
    expect_data({2'h0, s});
    host.send({20'h0, s}, 12);
    wait_empty();
    // Long frame keeps the last sixteen bits
    s = 12'($random(seed));
    expect_data({2'h0, s});
    host.send({12'h0, 4'hA, 4'h0, s}, 20);
    wait_empty();
    // Fill the queue, one more is dropped, then drain with stalls
    dac_ready = 1'b0;
    for (int i = 0; i < 32; i++) begin
      send_word(SWL_CTL_LOAD, 14'($random(seed)));
    end
    check("word_ready", 16'h0, 16'(word_ready));
    host.send({16'h0, 2'h0, 14'h2AAA}, 16);
    check("overruns", 16'h1, 16'(n_over));
    // Clock enable low freezes the queue
    @(negedge core_clk);
    clk_en    = 1'b0;
    dac_ready = 1'b1;
    repeat (20) @(negedge core_clk);
    check("word_ready", 16'h0, 16'(word_ready));
    clk_en = 1'b1;
    fork
      wait_empty();
      repeat (300) @(negedge core_clk) dac_ready = 1'($random(seed));
    join
    dac_ready = 1'b1;
    check("word_ready", 16'h1, 16'(word_ready));
    // Leftover bits select rising edge without an update
    send_word(SWL_CTL_LOAD, 14'h3FFF);
    wait_empty();
    host.send(32'h0000_0320, 12);
    repeat (4) @(negedge core_clk);
    check("rising_mode", 16'h1, 16'(rising_mode));
    check("short frames", 16'h2, 16'(n_short));
    for (int i = 0; i < 4; i++) begin
      send_word(2'(i), 14'($random(seed)));
    end
    wait_empty();
    check("rising_mode", 16'h1, 16'(rising_mode));
    // Only reset restores falling-edge sampling
    reset = 1'b1;
    repeat (10) @(negedge core_clk);
    reset = 1'b0;
    check("current_output", 16'h0, 16'(current_output));
    check("rising_mode", 16'h0, 16'(rising_mode));
    repeat (4) @(negedge core_clk);
    send_word(SWL_CTL_LOAD, 14'h1555);
    wait_empty();
    print_verdict();
  end
endmodule

`default_nettype wire
